//--- logic/trace_cfg_pkg.sv
package trace_cfg_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_PROG_CTRL   = 12'h004;
  localparam logic [11:0] OFF_STATUS      = 12'h00c;
  localparam logic [11:0] OFF_OPTIONS     = 12'h010;
  localparam logic [11:0] OFF_EVENT_SEL   = 12'h020;
  localparam logic [11:0] OFF_EVENT_BEH   = 12'h024;
  localparam logic [11:0] OFF_STALL_CTRL  = 12'h02c;
  localparam logic [11:0] OFF_CAPABILITY3 = 12'h1e4;

  // ----------------------------------------------------------------
  // field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int          PROG_EN_BIT       = 0;
  localparam int          STAT_IDLE_BIT     = 0;
  localparam int          STAT_STABLE_BIT   = 1;
  localparam int          CAP_STALL_BIT     = 26;
  localparam logic [31:0] OPTIONS_MASK      = 32'h0003_ffde;
  localparam logic [31:0] EVENT_SEL_MASK    = 32'h0000_00ff;
  localparam logic [31:0] EVENT_BEH_MASK    = 32'h0000_0003;
  localparam logic [31:0] STALL_MASK        = 32'h0000_3f0f;
  localparam logic [31:0] RESET_WORD        = 32'h0000_0000;
  localparam logic        STALL_SUPPORTED   = 1'b1;
  localparam logic [3:0]  LEVEL_NONE        = 4'h0;
  localparam logic [3:0]  LEVEL_MAX         = 4'hf;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;

  // register index, one code per mapped word
  typedef enum logic [2:0]
  {
    IDX_NONE, IDX_PROG, IDX_STAT, IDX_OPT, IDX_ESEL, IDX_EBEH, IDX_STALL, IDX_CAP
  } reg_idx_t;

  typedef struct packed
  {
    logic [13:0] rsvd_hi;
    logic        data_value_trace_en;
    logic        data_addr_trace_en;
    logic        vmid_opt;
    logic [1:0]  q_element_mode;
    logic        return_stack_en;
    logic        timestamp_en;
    logic [2:0]  cond_mode;
    logic        vmid_en;
    logic        context_id_en;
    logic        rsvd_5;
    logic        cycle_count_en;
    logic        branch_bcast_en;
    logic        store_as_p0;
    logic        load_as_p0;
    logic        rsvd_0;
  } trace_options_t;

  typedef struct packed
  {
    logic [29:0] rsvd;
    logic        event_data_trace_en;
    logic        event_inst_trace_en;
  } event_behaviour_t;

  typedef struct packed
  {
    logic [17:0] rsvd_hi;
    logic        no_overflow;
    logic        discard_store;
    logic        discard_load;
    logic        inst_priority;
    logic        data_stall;
    logic        inst_stall;
    logic [3:0]  rsvd_lo;
    logic [3:0]  level;
  } overflow_ctrl_t;

endpackage : trace_cfg_pkg

//--- logic/cycle_count_keeper.sv
// holds back cycle counts while output is suppressed and folds them into the next one sent
module cycle_count_keeper
  import trace_cfg_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        cc_valid,
  input  wire logic [15:0] cc_value,
  input  wire logic        suppress,
  output logic             cc_out_valid,
  output logic [15:0]      cc_out
);

  logic [15:0] acc_q;
  logic [15:0] acc_d;
  logic        vld_q;
  logic        vld_d;
  logic [15:0] out_q;
  logic [15:0] out_d;

  // ----------------------------------------------------------------
  // accumulate or emit
  // ----------------------------------------------------------------
  always_comb
  begin
    acc_d = acc_q;
    vld_d = 1'b0;
    out_d = out_q;
    if (cc_valid && suppress)
    begin
      acc_d = 16'(acc_q + cc_value);
    end
    else if (cc_valid)
    begin
      vld_d = 1'b1;
      out_d = 16'(acc_q + cc_value);
      acc_d = 16'h0000;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_q <= 16'h0000;
      vld_q <= 1'b0;
      out_q <= 16'h0000;
    end
    else
    begin
      acc_q <= acc_d;
      vld_q <= vld_d;
      out_q <= out_d;
    end
  end

  assign cc_out_valid = vld_q;
  assign cc_out       = out_q;

  a_cc_total_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    cc_valid && !suppress |=> cc_out_valid && cc_out == 16'($past(acc_q) + $past(cc_value)))
    else $error("cycle count lost held-back cycles");

endmodule : cycle_count_keeper

//--- logic/trace_event_overflow_cfg.sv
module trace_event_overflow_cfg
  import trace_cfg_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [11:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [11:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic [255:0] trace_events,
  input  wire logic [7:0]   inst_buf_space,
  input  wire logic [7:0]   data_buf_space,
  input  wire logic         ts_request,
  input  wire logic         cc_valid,
  input  wire logic [15:0]  cc_value,
  output logic              trace_enabled,
  output trace_options_t    trace_options,
  output logic              inst_event_elem,
  output logic              data_event_elem,
  output logic              inst_ts_emit,
  output logic              data_ts_emit,
  output logic              stall_processor,
  output logic              inst_priority_on,
  output logic              discard_load_on,
  output logic              discard_store_on,
  output logic              cc_out_valid,
  output logic [15:0]       cc_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic             en_q, en_d, idle_q, idle_d;
  trace_options_t   opt_q, opt_d;
  logic [7:0]       esel_q, esel_d;
  event_behaviour_t ebeh_q, ebeh_d;
  overflow_ctrl_t   stall_q, stall_d;
  logic             aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [11:0]      awaddr_q, awaddr_d;
  logic [31:0]      wdata_q, wdata_d;
  logic [3:0]       wstrb_q, wstrb_d;
  logic             bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]       bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]      rdata_q, rdata_d;
  logic             ievt_q, ievt_d, devt_q, devt_d;
  logic             its_q, its_d, dts_q, dts_d;
  logic             aw_take, w_take, ar_take, do_write, cfg_open;
  logic [11:0]      wr_addr;
  logic [31:0]      wr_data;
  logic [3:0]       wr_strb;
  logic             inst_low, data_low, ts_suppress;

  // map a byte address onto a register index
  function automatic reg_idx_t decode(input logic [11:0] a);
    case (a)
      OFF_PROG_CTRL:   decode = IDX_PROG;
      OFF_STATUS:      decode = IDX_STAT;
      OFF_OPTIONS:     decode = IDX_OPT;
      OFF_EVENT_SEL:   decode = IDX_ESEL;
      OFF_EVENT_BEH:   decode = IDX_EBEH;
      OFF_STALL_CTRL:  decode = IDX_STALL;
      OFF_CAPABILITY3: decode = IDX_CAP;
      default:         decode = IDX_NONE;
    endcase
  endfunction : decode

  // merge byte lanes of a write into an old value, keeping only defined bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = ((old & ~m) | (nw & m)) & mask;
  endfunction : merge

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign aw_take  = s_axi_awvalid && s_axi_awready;
  assign w_take   = s_axi_wvalid && s_axi_wready;
  assign ar_take  = s_axi_arvalid && s_axi_arready;
  assign do_write = (aw_hold_q || aw_take) && (w_hold_q || w_take);
  assign wr_addr  = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wr_data  = w_hold_q ? wdata_q : s_axi_wdata;
  assign wr_strb  = w_hold_q ? wstrb_q : s_axi_wstrb;
  assign cfg_open = !en_q && idle_q;

  // write channel, register writes and enable / idle tracking
  always_comb
  begin
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awaddr_d  = aw_take ? s_axi_awaddr : awaddr_q;
    wdata_d   = w_take ? s_axi_wdata : wdata_q;
    wstrb_d   = w_take ? s_axi_wstrb : wstrb_q;
    bvalid_d  = bvalid_q && !s_axi_bready;
    bresp_d   = bresp_q;
    en_d      = en_q;
    opt_d     = opt_q;
    esel_d    = esel_q;
    ebeh_d    = ebeh_q;
    stall_d   = stall_q;
    idle_d    = !en_q;  // idle one cycle after tracing stops
    if (aw_take)
    begin
      aw_hold_d = 1'b1;
    end
    if (w_take)
    begin
      w_hold_d = 1'b1;
    end
    if (do_write)
    begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (decode(wr_addr) == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (decode(wr_addr))
        IDX_PROG:
        begin
          if (wr_strb[0])
          begin
            en_d = wr_data[PROG_EN_BIT];
          end
        end
        IDX_OPT:   opt_d   = cfg_open ? trace_options_t'(merge(opt_q, wr_data, wr_strb, OPTIONS_MASK)) : opt_q;
        IDX_ESEL:  esel_d  = cfg_open ? 8'(merge({24'h0, esel_q}, wr_data, wr_strb, EVENT_SEL_MASK)) : esel_q;
        IDX_EBEH:  ebeh_d  = cfg_open ? event_behaviour_t'(merge(ebeh_q, wr_data, wr_strb, EVENT_BEH_MASK)) : ebeh_q;
        IDX_STALL: stall_d = cfg_open ? overflow_ctrl_t'(merge(stall_q, wr_data, wr_strb, STALL_MASK)) : stall_q;
        default:   en_d    = en_q;
      endcase
    end
  end

  // read channel
  always_comb
  begin
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (ar_take)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (decode(s_axi_araddr))
        IDX_PROG:  rdata_d = {31'h0, en_q};
        IDX_STAT:  rdata_d = {30'h0, idle_q, idle_q};
        IDX_OPT:   rdata_d = opt_q;
        IDX_ESEL:  rdata_d = {24'h0, esel_q};
        IDX_EBEH:  rdata_d = ebeh_q;
        IDX_STALL: rdata_d = stall_q;
        IDX_CAP:   rdata_d = 32'(STALL_SUPPORTED) << CAP_STALL_BIT;
        default:
        begin
          rdata_d = RESET_WORD;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // trace side
  // ----------------------------------------------------------------
  assign inst_low    = (stall_q.level != LEVEL_NONE) && (inst_buf_space < {4'h0, stall_q.level});
  assign data_low    = (stall_q.level != LEVEL_NONE) && (data_buf_space < {4'h0, stall_q.level});
  assign ts_suppress = inst_low || data_low;

  // event elements and timestamps, only while tracing
  always_comb
  begin
    ievt_d = en_q && trace_events[esel_q] && ebeh_q.event_inst_trace_en;
    devt_d = en_q && trace_events[esel_q] && ebeh_q.event_data_trace_en;
    its_d  = en_q && ts_request && opt_q.timestamp_en && !ts_suppress;
    dts_d  = its_d && (opt_q.data_addr_trace_en || opt_q.data_value_trace_en);
  end

  // all state registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {en_q, idle_q}      <= 2'b01;
      opt_q               <= trace_options_t'(RESET_WORD);
      esel_q              <= 8'h00;
      ebeh_q              <= event_behaviour_t'(RESET_WORD);
      stall_q             <= overflow_ctrl_t'(RESET_WORD);
      {aw_hold_q, w_hold_q} <= 2'b00;
      awaddr_q            <= 12'h000;
      wdata_q             <= 32'h0000_0000;
      wstrb_q             <= 4'h0;
      {bvalid_q, rvalid_q} <= 2'b00;
      {bresp_q, rresp_q}  <= 4'h0;
      rdata_q             <= 32'h0000_0000;
      {ievt_q, devt_q, its_q, dts_q} <= 4'h0;
    end
    else
    begin
      {en_q, idle_q}      <= {en_d, idle_d};
      {opt_q, esel_q, ebeh_q, stall_q} <= {opt_d, esel_d, ebeh_d, stall_d};
      {aw_hold_q, w_hold_q} <= {aw_hold_d, w_hold_d};
      {awaddr_q, wdata_q, wstrb_q} <= {awaddr_d, wdata_d, wstrb_d};
      {bvalid_q, rvalid_q} <= {bvalid_d, rvalid_d};
      {bresp_q, rresp_q, rdata_q} <= {bresp_d, rresp_d, rdata_d};
      {ievt_q, devt_q, its_q, dts_q} <= {ievt_d, devt_d, its_d, dts_d};
    end
  end

  cycle_count_keeper u_cc
  (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .cc_valid     (cc_valid && en_q && opt_q.cycle_count_en),
    .cc_value     (cc_value),
    .suppress     (inst_low),
    .cc_out_valid (cc_out_valid),
    .cc_out       (cc_out)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_rvalid     = rvalid_q;
  assign s_axi_rresp      = rresp_q;
  assign s_axi_rdata      = rdata_q;
  assign trace_enabled    = en_q;
  assign trace_options    = opt_q;
  assign inst_event_elem  = ievt_q;
  assign data_event_elem  = devt_q;
  assign inst_ts_emit     = its_q;
  assign data_ts_emit     = dts_q;
  assign stall_processor  = (stall_q.inst_stall && inst_low) || (stall_q.data_stall && data_low);
  assign inst_priority_on = stall_q.inst_priority && inst_low;
  assign discard_load_on  = stall_q.discard_load && data_low;
  assign discard_store_on = stall_q.discard_store && data_low;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cfg_write_closed;
    do_write && !cfg_open && decode(wr_addr) == IDX_STALL;
  endsequence

  a_event_inst_elem: assert property (@(posedge aclk) disable iff (!aresetn)
    en_q && trace_events[esel_q] && ebeh_q.event_inst_trace_en |=> inst_event_elem)
    else $error("selected event gave no instruction element");
  a_event_data_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    data_event_elem |-> $past(ebeh_q.event_data_trace_en) && $past(en_q))
    else $error("data element without data enable");
  a_write_dropped: assert property (@(posedge aclk) disable iff (!aresetn)
    s_cfg_write_closed |=> $stable(stall_q))
    else $error("config write taken while enabled or busy");
  a_open_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && cfg_open && decode(wr_addr) == IDX_ESEL && wr_strb[0] |=> esel_q == $past(wr_data[7:0]))
    else $error("config write lost while idle");
  a_level_zero_free: assert property (@(posedge aclk) disable iff (!aresetn)
    stall_q.level == LEVEL_NONE |-> !stall_processor && !discard_load_on && !discard_store_on)
    else $error("intrusion at level zero");
  a_stall_low_space: assert property (@(posedge aclk) disable iff (!aresetn)
    stall_q.inst_stall && stall_q.level != LEVEL_NONE && inst_buf_space < {4'h0, stall_q.level}
    |-> stall_processor)
    else $error("no stall with low instruction space");
  a_ts_suppressed: assert property (@(posedge aclk) disable iff (!aresetn)
    inst_ts_emit |-> $past(!ts_suppress) && $past(ts_request))
    else $error("timestamp while suppressed");
  a_reset_zero: assert property (@(posedge aclk)
    !aresetn |=> opt_q == RESET_WORD && esel_q == 8'h00 && stall_q == RESET_WORD && ebeh_q == RESET_WORD)
    else $error("config not zero after reset");
  a_bresp_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid [*1] ##0 (s_axi_bresp == RESP_SLVERR) == (decode($past(wr_addr)) == IDX_NONE))
    else $error("write answer wrong");

endmodule : trace_event_overflow_cfg

//--- bench/trace_source_model.sv
// far side: traced processor events, buffer levels, timestamp and cycle count requests
module trace_source_model
(
  input  wire logic    aclk,
  output logic [255:0] trace_events,
  output logic [7:0]   inst_buf_space,
  output logic [7:0]   data_buf_space,
  output logic         ts_request,
  output logic         cc_valid,
  output logic [15:0]  cc_value
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: no events, buffers roomy
  initial
  begin
    trace_events = '0;
    inst_buf_space = 8'hff;
    data_buf_space = 8'hff;
    ts_request = 1'b0;
    cc_valid = 1'b0;
    cc_value = 16'h0;
  end

  // new free space levels, taken from the next edge on
  task automatic set_space(input logic [7:0] si, input logic [7:0] sd);
    @(posedge aclk);
    inst_buf_space <= si;
    data_buf_space <= sd;
  endtask : set_space

  // one cycle of event, timestamp request and cycle count
  task automatic fire(input logic [7:0] ev, input logic ts, input logic ccv, input logic [15:0] ccval);
    @(posedge aclk);
    trace_events <= 256'h1 << ev;
    ts_request <= ts;
    cc_valid <= ccv;
    cc_value <= ccval;
    @(posedge aclk);
    trace_events <= '0;
    ts_request <= 1'b0;
    cc_valid <= 1'b0;
    cc_value <= ~ccval; // released value is not held
  endtask : fire
endmodule : trace_source_model

//--- bench/testbench.sv
module testbench
  import trace_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] OPT = 32'h0000_0810; // timestamps and cycle counts on
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ts_request, cc_valid, cc_out_valid;
  logic trace_enabled, inst_event_elem, data_event_elem, inst_ts_emit, data_ts_emit;
  logic stall_processor, inst_priority_on, discard_load_on, discard_store_on;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, wd;
  logic [3:0] s_axi_wstrb, lv, ws;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [255:0] trace_events;
  logic [7:0] inst_buf_space, data_buf_space, si, sd, k;
  logic [15:0] cc_value, cc_out, held, v, sum;
  trace_options_t trace_options;
  int err_count, n_checks, cyc;
  integer seed;
  logic [11:0] offs [4] = '{OFF_OPTIONS, OFF_EVENT_SEL, OFF_EVENT_BEH, OFF_STALL_CTRL};
  logic [31:0] masks [4] = '{OPTIONS_MASK, EVENT_SEL_MASK, EVENT_BEH_MASK, STALL_MASK};
  logic [31:0] shadow [4] = '{32'h0, 32'h0, 32'h0, 32'h0};

  trace_event_overflow_cfg dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trace_events,
    .inst_buf_space, .data_buf_space, .ts_request, .cc_valid, .cc_value, .trace_enabled, .trace_options,
    .inst_event_elem, .data_event_elem, .inst_ts_emit, .data_ts_emit, .stall_processor, .inst_priority_on,
    .discard_load_on, .discard_store_on, .cc_out_valid, .cc_out);
  trace_source_model src (.aclk, .trace_events, .inst_buf_space, .data_buf_space, .ts_request, .cc_valid,
    .cc_value);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) r[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    return r & m;
  endfunction : merge

  // buffer below a nonzero threshold
  function automatic logic low(input logic [3:0] l, input logic [7:0] sp);
    return (l != 4'h0) && ({4'h0, l} > sp);
  endfunction : low

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // ready is sampled mid-cycle, where it equals its value at the coming edge
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bh = 1'b0;
    while (!bh)
    begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a);
    logic ah, rh;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rh = 1'b0;
    while (!rh)
    begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid && s_axi_rready;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axi_read

  // disable, check idle, program, enable
  task automatic cfg(input logic [31:0] beh, sel, stl);
    axi_write(OFF_PROG_CTRL, 32'h0, 4'hf);
    axi_read(OFF_STATUS);
    chk(32'(rd[STAT_IDLE_BIT]), 32'h1);
    axi_write(OFF_EVENT_BEH, beh, 4'hf);
    axi_write(OFF_EVENT_SEL, sel, 4'hf);
    axi_write(OFF_OPTIONS, OPT, 4'hf);
    axi_read(OFF_CAPABILITY3);
    if (rd[CAP_STALL_BIT] === 1'b1) axi_write(OFF_STALL_CTRL, stl, 4'hf);
    axi_write(OFF_PROG_CTRL, 32'h1, 4'hf);
  endtask : cfg

  // ----------------------------------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // cut a hang short
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  initial
  begin
    seed = 32'hfb9db7b9;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i])
    begin
      axi_read(offs[i]);
      chk(rd, RESET_WORD);
    end
    axi_read(OFF_CAPABILITY3);
    chk(32'(rd[CAP_STALL_BIT]), 32'(STALL_SUPPORTED));
    axi_read(12'h3f0);
    chk(32'(resp), 32'(RESP_SLVERR));
    axi_write(12'h3f0, 32'h1, 4'hf);
    chk(32'(resp), 32'(RESP_SLVERR));
    // random writes with random strobes while disabled
    for (int n = 0; n < 12; n++)
    begin
      wd = $random(seed);
      ws = 4'($random(seed));
      shadow[n % 4] = merge(shadow[n % 4], wd, ws, masks[n % 4]);
      axi_write(offs[n % 4], wd, ws);
      axi_read(offs[n % 4]);
      chk(rd, shadow[n % 4]);
    end
    // writes while enabled change nothing
    axi_write(OFF_PROG_CTRL, 32'h1, 4'hf);
    axi_read(OFF_STATUS);
    chk(32'(rd[STAT_IDLE_BIT]), 32'h0);
    foreach (offs[i])
    begin
      axi_write(offs[i], ~shadow[i], 4'hf);
      axi_read(offs[i]);
      chk(rd, shadow[i]);
    end
    // every behaviour code, selected and neighbouring event
    for (int b = 0; b < 4; b++)
    begin
      k = 8'($random(seed));
      cfg(32'(b), 32'(k), 32'h0);
      chk(32'(trace_enabled), 32'h1);
      chk(32'(trace_options), OPT & OPTIONS_MASK);
      src.fire(k, 1'b0, 1'b0, 16'h0);
      #1;
      chk(32'({inst_event_elem, data_event_elem}), 32'({b[0], b[1]}));
      src.fire(k ^ 8'h01, 1'b0, 1'b0, 16'h0);
      #1;
      chk(32'({inst_event_elem, data_event_elem}), 32'h0);
    end
    // threshold levels against buffer space
    held = 16'h0;
    for (int n = 0; n < 8; n++)
    begin
      lv = (n == 0) ? 4'h0 : (n == 1) ? 4'hf : 4'($random(seed));
      cfg(32'h3, 32'h0, {19'h0, 5'h1f, 4'h0, lv});
      for (int m = 0; m < 4; m++)
      begin
        si = (m == 0) ? 8'h0 : (m == 3) ? 8'hff : 8'($unsigned($random(seed)) % 20);
        sd = (m == 0) ? {4'h0, lv} : (m == 3) ? 8'hff : 8'($unsigned($random(seed)) % 20);
        src.set_space(si, sd);
        #1;
        chk(32'(stall_processor), 32'(low(lv, si) | low(lv, sd)));
        chk(32'({inst_priority_on, discard_load_on, discard_store_on}), 32'({low(lv, si), {2{low(lv, sd)}}}));
        v = 16'($unsigned($random(seed)) % 1000);
        src.fire(8'h0, 1'b1, 1'b1, v);
        #1;
        // data stream timestamps only go out while data address or value tracing is on
        chk(32'({inst_ts_emit, data_ts_emit}), 32'({1'b1, OPT[17:16] != 2'b00} & {2{!(low(lv, si) | low(lv, sd))}}));
        chk(32'(cc_out_valid), 32'(!low(lv, si)));
        sum = held + v;
        if (!low(lv, si)) chk(32'(cc_out), 32'(sum));
        held = low(lv, si) ? sum : 16'h0;
      end
    end
    final_report();
  end
endmodule : testbench
